// *** crf_core_regs.sv ***
// Dedicated CPU registers, flag logic and interrupt gate behind Avalon-MM.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`include "crf_defs.svh"

module crf_core_regs #(
    parameter int GPR_BANKS = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`CRF_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic irq_req_i,
    input wire logic [1:0] irq_level_i,
    output logic irq_take_o,
    output crf_pkg::crf_word_t prog_counter_o,
    output crf_pkg::crf_word_t status_word_o
);
    import crf_pkg::*;

    // Elaboration refuses a bank count that the bank pointer cannot reach.
    if (GPR_BANKS < 1 || GPR_BANKS > 16) begin : g_bad_banks
        $error("GPR_BANKS must lie between 1 and 16.");
    end

    crf_word_t prog_counter_q;
    crf_word_t accum_q;
    crf_word_t temp_accum_q;
    crf_word_t index_reg_q;
    crf_word_t extra_ptr_q;
    crf_word_t stack_ptr_q;
    crf_word_t status_word_q;
    crf_word_t probe_addr_q;
    logic [2:0] gpr_idx_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic irq_take_q;

    logic req;
    logic accept;
    logic wr_acc;
    logic [31:0] rdata_d;

    // A request is seen with waitrequest high, read data is loaded, then
    // waitrequest drops for one cycle and that edge completes the access.
    assign req = avs_read_i | avs_write_i;
    assign accept = req & ~wait_q;
    assign wr_acc = accept & avs_write_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Region and register-bank address computation.
    crf_region_t probe_region;
    crf_word_t gpr_addr;
    logic [3:0] bank_num;

    always_comb begin
        if (probe_addr_q < `CRF_IO_END) begin
            probe_region = CRF_REGION_IO;
        end else if (probe_addr_q < `CRF_PROG_BASE) begin
            probe_region = CRF_REGION_DATA;
        end else begin
            probe_region = CRF_REGION_PROG;
        end
    end

    // Bank numbers beyond the fitted bank count wrap into the fitted range.
    // The divisor is five bits wide so that a count of 16 does not become 0.
    assign bank_num = 4'({1'b0, status_word_q[11:8]} % 5'(GPR_BANKS));
    assign gpr_addr = `CRF_GPR_BASE + {9'h000, bank_num, gpr_idx_q};

    // Flag unit.
    logic [2:0] op;
    logic [16:0] res;
    logic [4:0] nib;
    logic f_c;
    logic f_h;
    logic f_v;
    logic f_n;
    logic f_z;
    logic is_word;
    logic is_shift;
    logic alu_go;

    assign op = avs_writedata_i[2:0];
    assign alu_go = wr_acc && (avs_address_i == `CRF_OFF_ALU_CMD);

    always_comb begin
        res = 17'h00000;
        nib = 5'h00;
        is_word = 1'b0;
        is_shift = 1'b0;
        case (op)
            `CRF_OP_ADDB: begin
                res = {9'h000, accum_q[7:0]} + {9'h000, temp_accum_q[7:0]};
                nib = {1'b0, accum_q[3:0]} + {1'b0, temp_accum_q[3:0]};
            end
            `CRF_OP_SUBB: begin
                res = {9'h000, accum_q[7:0]} - {9'h000, temp_accum_q[7:0]};
                nib = {1'b0, accum_q[3:0]} - {1'b0, temp_accum_q[3:0]};
            end
            `CRF_OP_SHLB: begin
                is_shift = 1'b1;
                res = {8'h00, accum_q[7:0], 1'b0};
            end
            `CRF_OP_SHRB: begin
                is_shift = 1'b1;
                res = {9'h000, 1'b0, accum_q[7:1]};
            end
            `CRF_OP_ADDW: begin
                is_word = 1'b1;
                res = {1'b0, accum_q} + {1'b0, temp_accum_q};
                nib = {1'b0, accum_q[3:0]} + {1'b0, temp_accum_q[3:0]};
            end
            `CRF_OP_SUBW: begin
                is_word = 1'b1;
                res = {1'b0, accum_q} - {1'b0, temp_accum_q};
                nib = {1'b0, accum_q[3:0]} - {1'b0, temp_accum_q[3:0]};
            end
            default: begin
                res = {9'h000, accum_q[7:0]};
            end
        endcase
    end

    always_comb begin
        f_h = nib[4];
        if (is_word) begin
            f_c = res[16];
            f_n = res[15];
            f_z = (res[15:0] == 16'h0000);
            if (op == `CRF_OP_ADDW) begin
                f_v = (accum_q[15] == temp_accum_q[15])
                    && (res[15] != accum_q[15]);
            end else begin
                f_v = (accum_q[15] != temp_accum_q[15])
                    && (res[15] != accum_q[15]);
            end
        end else begin
            f_n = res[7];
            f_z = (res[7:0] == 8'h00);
            if (op == `CRF_OP_SHLB) begin
                f_c = accum_q[7];
            end else if (op == `CRF_OP_SHRB) begin
                f_c = accum_q[0];
            end else begin
                f_c = res[8];
            end
            if (op == `CRF_OP_ADDB) begin
                f_v = (accum_q[7] == temp_accum_q[7])
                    && (res[7] != accum_q[7]);
            end else if (op == `CRF_OP_SUBB) begin
                f_v = (accum_q[7] != temp_accum_q[7])
                    && (res[7] != accum_q[7]);
            end else begin
                f_v = 1'b0;
            end
        end
    end

    // Register updates; the three pointer registers share one process, as do the bank index and probe address.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_counter_q <= `CRF_RST_PROG_COUNTER;
        end else if (wr_acc && avs_address_i == `CRF_OFF_PROG_COUNTER) begin
            prog_counter_q <= avs_writedata_i[15:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accum_q <= `CRF_RST_WORD;
        end else if (alu_go && is_word) begin
            accum_q <= res[15:0];
        end else if (alu_go) begin
            accum_q <= {accum_q[15:8], res[7:0]};
        end else if (wr_acc && avs_address_i == `CRF_OFF_ACCUM) begin
            accum_q <= avs_writedata_i[15:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_accum_q <= `CRF_RST_WORD;
        end else if (wr_acc && avs_address_i == `CRF_OFF_TEMP_ACCUM) begin
            temp_accum_q <= avs_writedata_i[15:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            index_reg_q <= `CRF_RST_WORD;
            extra_ptr_q <= `CRF_RST_WORD;
            stack_ptr_q <= `CRF_RST_WORD;
        end else if (wr_acc) begin
            if (avs_address_i == `CRF_OFF_INDEX_REG) begin
                index_reg_q <= avs_writedata_i[15:0];
            end
            if (avs_address_i == `CRF_OFF_EXTRA_PTR) begin
                extra_ptr_q <= avs_writedata_i[15:0];
            end
            if (avs_address_i == `CRF_OFF_STACK_PTR) begin
                stack_ptr_q <= avs_writedata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_word_q <= `CRF_RST_STATUS_WORD;
        end else if (alu_go) begin
            status_word_q[`CRF_BIT_C] <= f_c;
            status_word_q[`CRF_BIT_Z] <= f_z;
            status_word_q[`CRF_BIT_N] <= f_n;
            if (!is_shift) begin
                status_word_q[`CRF_BIT_H] <= f_h;
                status_word_q[`CRF_BIT_V] <= f_v;
            end
        end else if (wr_acc && avs_address_i == `CRF_OFF_STATUS_WORD) begin
            status_word_q <= avs_writedata_i[15:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpr_idx_q <= 3'h0;
            probe_addr_q <= 16'h0000;
        end else if (wr_acc) begin
            if (avs_address_i == `CRF_OFF_GPR_ADDR) begin
                gpr_idx_q <= avs_writedata_i[2:0];
            end
            if (avs_address_i == `CRF_OFF_REGION) begin
                probe_addr_q <= avs_writedata_i[15:0];
            end
        end
    end

    // Read data is prepared while waitrequest is still high.
    always_comb begin
        case (avs_address_i)
            `CRF_OFF_PROG_COUNTER: rdata_d = {16'h0000, prog_counter_q};
            `CRF_OFF_ACCUM: rdata_d = {16'h0000, accum_q};
            `CRF_OFF_TEMP_ACCUM: rdata_d = {16'h0000, temp_accum_q};
            `CRF_OFF_INDEX_REG: rdata_d = {16'h0000, index_reg_q};
            `CRF_OFF_EXTRA_PTR: rdata_d = {16'h0000, extra_ptr_q};
            `CRF_OFF_STACK_PTR: rdata_d = {16'h0000, stack_ptr_q};
            `CRF_OFF_STATUS_WORD: rdata_d = {16'h0000, status_word_q};
            `CRF_OFF_GPR_ADDR: rdata_d = {13'h0000, gpr_idx_q, gpr_addr};
            `CRF_OFF_REGION: rdata_d = {14'h0000, probe_region, probe_addr_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    // A request wins when enabled and its level code is below the mask code.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_take_q <= 1'b0;
        end else begin
            irq_take_q <= irq_req_i && status_word_q[`CRF_BIT_I]
                && (irq_level_i < {status_word_q[`CRF_BIT_IL1],
                                   status_word_q[`CRF_BIT_IL0]});
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign irq_take_o = irq_take_q;
    assign prog_counter_o = prog_counter_q;
    assign status_word_o = status_word_q;

endmodule : crf_core_regs

// *** crf_core_regs_sva.sv ***
// Checker for the bus handshake, register outputs and interrupt gate.
`include "crf_defs.svh"
module crf_core_regs_sva #(
    parameter int GPR_BANKS = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`CRF_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic irq_req_i,
    input wire logic [1:0] irq_level_i,
    input wire logic irq_take_o,
    input wire crf_pkg::crf_word_t prog_counter_o,
    input wire crf_pkg::crf_word_t status_word_o
);
    import crf_pkg::*;
    logic irq_ok;
    logic pc_wr;
    logic sw_wr;
    // The request level code must lie strictly below the mask level code.
    assign irq_ok = irq_req_i && status_word_o[`CRF_BIT_I] && (irq_level_i <
        {status_word_o[`CRF_BIT_IL1], status_word_o[`CRF_BIT_IL0]});
    assign pc_wr = avs_write_i && !avs_waitrequest_o &&
        avs_address_i == `CRF_OFF_PROG_COUNTER;
    assign sw_wr = avs_write_i && !avs_waitrequest_o &&
        avs_address_i == `CRF_OFF_STATUS_WORD;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
    AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("answer too long");
    AST_IDLE_WAIT: assert property (!avs_read_i && !avs_write_i &&
        avs_waitrequest_o |=> avs_waitrequest_o) else $error("idle answer");
    AST_PC_WR: assert property (pc_wr |=>
        prog_counter_o == $past(avs_writedata_i[15:0])) else $error("pc wr");
    AST_PC_HOLD: assert property (!pc_wr |=>
        $stable(prog_counter_o)) else $error("pc moved");
    AST_SW_WR: assert property (sw_wr |=>
        status_word_o == $past(avs_writedata_i[15:0])) else $error("sw wr");
    AST_RD_SW: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == `CRF_OFF_STATUS_WORD |->
        avs_readdata_o == {16'h0000, status_word_o}) else $error("sw rd");
    AST_IRQ_TAKE: assert property (irq_ok |=> irq_take_o)
        else $error("irq not taken");
    AST_IRQ_BLOCK: assert property (!irq_ok |=> !irq_take_o)
        else $error("irq taken");
endmodule : crf_core_regs_sva

// *** crf_defs.svh ***
// Offsets, field positions, reset values and codes of the CPU register file.
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

`define CRF_AW 8
`define CRF_OFF_PROG_COUNTER 8'h00
`define CRF_OFF_ACCUM 8'h04
`define CRF_OFF_TEMP_ACCUM 8'h08
`define CRF_OFF_INDEX_REG 8'h0C
`define CRF_OFF_EXTRA_PTR 8'h10
`define CRF_OFF_STACK_PTR 8'h14
`define CRF_OFF_STATUS_WORD 8'h18
`define CRF_OFF_ALU_CMD 8'h1C
`define CRF_OFF_GPR_ADDR 8'h20
`define CRF_OFF_REGION 8'h24

`define CRF_RST_PROG_COUNTER 16'h0000
`define CRF_RST_WORD 16'h0000
`define CRF_RST_STATUS_WORD 16'h0000

`define CRF_BIT_C 0
`define CRF_BIT_V 1
`define CRF_BIT_Z 2
`define CRF_BIT_N 3
`define CRF_BIT_IL0 4
`define CRF_BIT_IL1 5
`define CRF_BIT_I 6
`define CRF_BIT_H 7

`define CRF_OP_ADDB 3'h0
`define CRF_OP_SUBB 3'h1
`define CRF_OP_SHLB 3'h2
`define CRF_OP_SHRB 3'h3
`define CRF_OP_ADDW 3'h4
`define CRF_OP_SUBW 3'h5

`define CRF_IO_END 16'h0080
`define CRF_PROG_BASE 16'h8000
`define CRF_GPR_BASE 16'h0100

`endif

// *** crf_pkg.sv ***
// Types shared by the CPU register file.
package crf_pkg;
    typedef enum logic [1:0] {
        CRF_REGION_IO,
        CRF_REGION_DATA,
        CRF_REGION_PROG
    } crf_region_t;
    typedef logic [15:0] crf_word_t;
endpackage : crf_pkg

// *** tb.sv ***
// Testbench for the CPU register file, with the checker bound in.
`include "crf_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import crf_pkg::*;
    logic clk_i;
    logic rst_n_i;
    logic [7:0] adr;
    logic rd_i;
    logic wr_i;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic wait_o;
    logic irq_req;
    logic [1:0] irq_lvl;
    logic take_o;
    crf_word_t pc_o;
    crf_word_t sw_o;
    int n_fail = 0;
    int tests_run = 0;
    crf_word_t ra[5] = '{16'h007F, 16'h0080, 16'h7FFF, 16'h8000, 16'hFFFF};
    crf_region_t rr[5] = '{CRF_REGION_IO, CRF_REGION_DATA, CRF_REGION_DATA,
        CRF_REGION_PROG, CRF_REGION_PROG};
    crf_core_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdat),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .irq_req_i(irq_req), .irq_level_i(irq_lvl), .irq_take_o(take_o),
        .prog_counter_o(pc_o), .status_word_o(sw_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // The request stands until waitrequest is sampled low, then drops.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clk_i);
        while (wait_o !== 1'b0 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) begin
            n_fail++;
        end
        q = rdat;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rdc
    // Presets the status byte, runs one operation, checks result and flags.
    task automatic alu(input logic [2:0] op, input crf_word_t a, t,
        input logic [7:0] pre, input crf_word_t ea, input logic [7:0] ef);
        wr(`CRF_OFF_STATUS_WORD, {24'h0, pre});
        wr(`CRF_OFF_ACCUM, {16'h0, a});
        wr(`CRF_OFF_TEMP_ACCUM, {16'h0, t});
        wr(`CRF_OFF_ALU_CMD, {29'h0, op});
        rdc(`CRF_OFF_ACCUM, {16'h0, ea});
        rdc(`CRF_OFF_STATUS_WORD, {24'h0, ef});
    endtask : alu
    initial begin
        rst_n_i <= 1'b0;
        adr <= 8'h00;
        rd_i <= 1'b0;
        wr_i <= 1'b0;
        wdat <= 32'h0;
        irq_req <= 1'b0;
        irq_lvl <= 2'h0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            wr(8'(4 * i), {16'hFFFF, 16'hA5C0 + 16'(i)});
            rdc(8'(4 * i), {16'h0, 16'hA5C0 + 16'(i)});
        end
        rdc(`CRF_OFF_ALU_CMD, 32'h0);
        wr(8'h28, 32'h1234);
        rdc(8'h28, 32'h0);
        $display("test registers done");
        alu(`CRF_OP_ADDB, 16'h1208, 16'h0008, 8'h00, 16'h1210, 8'h80);
        alu(`CRF_OP_ADDB, 16'h5580, 16'hFF80, 8'h00, 16'h5500, 8'h07);
        alu(`CRF_OP_ADDB, 16'h007F, 16'h0001, 8'h00, 16'h0080, 8'h8A);
        alu(`CRF_OP_SUBB, 16'h0010, 16'h0001, 8'h00, 16'h000F, 8'h80);
        alu(`CRF_OP_SUBB, 16'hAA00, 16'h0001, 8'h00, 16'hAAFF, 8'h89);
        alu(`CRF_OP_SHLB, 16'h0081, 16'h0000, 8'h82, 16'h0002, 8'h83);
        alu(`CRF_OP_SHRB, 16'h0001, 16'h0000, 8'h00, 16'h0000, 8'h05);
        alu(`CRF_OP_ADDW, 16'hFFFF, 16'h0001, 8'h00, 16'h0000, 8'h85);
        alu(`CRF_OP_SUBW, 16'h8000, 16'h0001, 8'h00, 16'h7FFF, 8'h82);
        $display("test flags done");
        wr(`CRF_OFF_STATUS_WORD, 32'h0500);
        wr(`CRF_OFF_GPR_ADDR, 32'h3);
        rdc(`CRF_OFF_GPR_ADDR, 32'h0003_012B);
        wr(`CRF_OFF_STATUS_WORD, 32'h0F00);
        wr(`CRF_OFF_GPR_ADDR, 32'h7);
        rdc(`CRF_OFF_GPR_ADDR, 32'h0007_017F);
        $display("test banks done");
        for (int i = 0; i < 5; i++) begin
            wr(`CRF_OFF_REGION, {16'h0, ra[i]});
            rdc(`CRF_OFF_REGION, {14'h0, rr[i], ra[i]});
        end
        $display("test regions done");
        for (int il = 0; il < 4; il++) begin
            for (int lv = 0; lv < 4; lv++) begin
                wr(`CRF_OFF_STATUS_WORD, {24'h0, 2'b01, 2'(il), 4'h0});
                irq_req <= 1'b1;
                irq_lvl <= 2'(lv);
                repeat (2) @(posedge clk_i);
                chk({31'h0, take_o}, {31'h0, lv < il});
            end
        end
        wr(`CRF_OFF_STATUS_WORD, 32'h0030);
        irq_lvl <= 2'h0;
        repeat (2) @(posedge clk_i);
        chk({31'h0, take_o}, 32'h0);
        $display("test interrupts done");
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        report_and_stop();
    end
endmodule : tb
bind crf_core_regs crf_core_regs_sva #(.GPR_BANKS(GPR_BANKS)) u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_req_i(irq_req_i),
    .irq_level_i(irq_level_i), .irq_take_o(irq_take_o),
    .prog_counter_o(prog_counter_o), .status_word_o(status_word_o));
